// File: pkg/prc_pkg.sv
// Constants shared by the prioritized register cell and its register slave
package prc_pkg;
  localparam int PRC_ADDR_W = 4;
  localparam int PRC_DATA_W = 32;
  localparam logic [PRC_ADDR_W-1:0] PRC_OFF_CTRL = 4'h0;
  localparam logic [PRC_ADDR_W-1:0] PRC_OFF_STATUS = 4'h4;
  localparam logic [PRC_ADDR_W-1:0] PRC_OFF_CAPCNT = 4'h8;
  localparam int PRC_CTRL_W = 3;
  localparam int PRC_CTRL_INV_BIT = 0;
  localparam int PRC_CTRL_CONST_EN_BIT = 1;
  localparam int PRC_CTRL_CONST_VAL_BIT = 2;
  localparam logic [PRC_CTRL_W-1:0] PRC_CTRL_RESET = 3'h0;
  localparam int PRC_ST_Q_BIT = 0;
  localparam int PRC_ST_RAW_BIT = 1;
  localparam int PRC_ST_ACLR_BIT = 2;
  localparam int PRC_ST_PRE_BIT = 3;
  localparam int PRC_ST_ALOAD_BIT = 4;
  localparam int PRC_ST_ENA_BIT = 5;
  localparam logic [PRC_DATA_W-1:0] PRC_CAPCNT_RESET = 32'h0000_0000;
  localparam logic PRC_RAW_POWERUP = 1'b0;
  localparam logic [1:0] PRC_RESP_OKAY = 2'h0;
  localparam logic [1:0] PRC_RESP_SLVERR = 2'h2;
endpackage

// File: tb/prc_cell_properties.sv
// Assertions tying the cell output to its control inputs
`timescale 1ns/100ps
module prc_cell_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic aclr,
  input wire logic pre,
  input wire logic aload,
  input wire logic aData,
  input wire logic ena,
  input wire logic sclr,
  input wire logic sload,
  input wire logic sData,
  input wire logic data,
  input wire logic q,
  input wire logic rawBit,
  input wire logic s_axi_bvalid
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic quiet, calm;
  assign quiet = !aclr && !pre && !aload;
  // A register write may flip the invert bit, so skip those cycles
  assign calm = quiet && !s_axi_bvalid;
  property p_clr; aclr |-> !q; endproperty
  a_clr: assert property (p_clr)
    else $error("q high under clear");
  property p_pre; !aclr && pre |-> q; endproperty
  a_pre: assert property (p_pre)
    else $error("q low under preset");
  property p_hold; quiet && !ena ##1 calm |-> $stable(q); endproperty
  a_hold: assert property (p_hold)
    else $error("q moved without enable");
  property p_cap; quiet && ena && !sclr && !sload ##1 calm |->
    q == $past(data); endproperty
  a_cap: assert property (p_cap)
    else $error("data not captured");
  property p_sclr; quiet && ena && sclr ##1 calm |-> !q; endproperty
  a_sclr: assert property (p_sclr)
    else $error("sync clear missed");
  property p_sload; quiet && ena && !sclr && sload ##1 calm |->
    q == $past(sData); endproperty
  a_sload: assert property (p_sload)
    else $error("sync load missed");
  property p_aload; aload && !aclr && !pre ##1 calm && !ena |->
    q == $past(aData); endproperty
  a_aload: assert property (p_aload)
    else $error("load data not kept");
  property p_power; $fell(rst) |-> !rawBit; endproperty
  a_power: assert property (p_power)
    else $error("stored bit not zero after reset");
endmodule
bind prc_cell_top prc_cell_checker i_prc_cell_checker (.*);

// File: tb/prc_user_logic.sv
// Surrounding user logic that drives the cell's control inputs
`timescale 1ns/100ps
module prc_user_logic (
  input wire logic clk,
  input wire logic rst,
  input wire logic [8:0] cmd,
  output logic aclr,
  output logic pre,
  output logic aload,
  output logic aData,
  output logic ena,
  output logic sclr,
  output logic sload,
  output logic sData,
  output logic data
);
  logic [8:0] ctl = 9'h000;
  // Every control leaves a flop, so no glitch reaches the async inputs
  always @(posedge clk or posedge rst) begin
    if (rst)
      ctl <= 9'h000;
    else
      ctl <= cmd;
  end
  assign {aclr, pre, aload, aData, ena, sclr, sload, sData, data} = ctl;
endmodule

// File: tb/test_prioritized_register_cell.sv
// Self-checking bench for the prioritized register cell
`timescale 1ns/100ps
module test_prioritized_register_cell
  import prc_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, q, rawBit;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic aclr, pre, aload, aData, ena, sclr, sload, sData, data;
  logic [8:0] cmd = 9'h000;
  int fails = 0, compares = 0;
  prc_cell_top i_prc_cell_top (.*);
  prc_user_logic i_prc_user_logic (.*);
  always #10 clk = ~clk;
  task automatic check(input string n, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // Inputs change after the edge; handshakes are sampled mid-cycle
  task automatic axiWrite(input logic [3:0] a, input logic [31:0] v,
      output logic [1:0] rs);
    logic aw, w, b;
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      rs = s_axi_bresp;
      n++;
      @(posedge clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end while (!b && n < 50);
    s_axi_bready <= 1'b0;
    if (!b) fails++;
  endtask
  task automatic axiRead(input logic [3:0] a, output logic [31:0] v,
      output logic [1:0] rs);
    logic ar, b;
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge clk);
      ar = s_axi_arvalid && s_axi_arready;
      b = s_axi_rvalid;
      v = s_axi_rdata;
      rs = s_axi_rresp;
      n++;
      @(posedge clk);
      if (ar) s_axi_arvalid <= 1'b0;
    end while (!b && n < 50);
    s_axi_rready <= 1'b0;
    if (!b) fails++;
  endtask
  // Partner registers cmd, so the cell sees it one edge later
  task automatic apply(input logic [8:0] c);
    @(posedge clk);
    cmd <= c;
    repeat (2) @(posedge clk);
    #1;
  endtask
  function automatic logic expQ(input logic [8:0] c, input logic p);
    if (c[8]) return 1'b0;
    if (c[7]) return 1'b1;
    if (c[6]) return c[5];
    if (!c[4]) return p;
    if (c[3]) return 1'b0;
    if (c[2]) return c[1];
    return c[0];
  endfunction
  task automatic tPowerUp;
    check("rawBit", 32'(rawBit), 32'h0);
    check("q", 32'(q), 32'h0);
    axiRead(PRC_OFF_CAPCNT, d, r);
    check("capcnt", d, PRC_CAPCNT_RESET);
    $display("test powerup done");
  endtask
  task automatic tPriority;
    logic e;
    e = 1'b0;
    for (int i = 0; i < 512; i++) begin
      apply(i[8:0]);
      e = expQ(i[8:0], e);
      check("q", 32'(q), 32'(e));
    end
    $display("test priority done");
  endtask
  task automatic tAsync;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      cmd <= {3'h1, i[0], 5'h00};
      @(posedge clk);
      #1;
      check("qFollow", 32'(q), 32'(i[0]));
    end
    // Sync clear must wait for the edge even while it stands
    apply(9'h011);
    @(posedge clk);
    cmd <= 9'h018;
    @(posedge clk);
    #1;
    check("qBeforeEdge", 32'(q), 32'h1);
    @(posedge clk);
    #1;
    check("qAfterEdge", 32'(q), 32'h0);
    $display("test async load done");
  endtask
  task automatic tInvert;
    // Clear must be gone before the mode flips, or it rewrites the bit
    apply(9'h100);
    apply(9'h000);
    axiWrite(PRC_OFF_CTRL, 32'h1, r);
    apply(9'h000);
    check("q", 32'(q), 32'h1);
    check("rawBit", 32'(rawBit), 32'h0);
    apply(9'h080);
    apply(9'h000);
    axiRead(PRC_OFF_STATUS, d, r);
    check("status", 32'(d[1:0]), 32'h1);
    apply(9'h010);
    check("q", 32'(q), 32'h0);
    check("rawBit", 32'(rawBit), 32'h1);
    axiWrite(PRC_OFF_CTRL, 32'h0, r);
    $display("test invert done");
  endtask
  task automatic tConst;
    axiWrite(PRC_OFF_CTRL, 32'h6, r);
    axiRead(PRC_OFF_CTRL, d, r);
    check("ctrl", d, 32'h6);
    apply(9'h040);
    check("q", 32'(q), 32'h1);
    check("rawBit", 32'(rawBit), 32'h1);
    axiWrite(PRC_OFF_CTRL, 32'h2, r);
    apply(9'h040);
    check("rawBit", 32'(rawBit), 32'h0);
    apply(9'h011);
    axiWrite(PRC_OFF_CTRL, 32'h0, r);
    $display("test const load done");
  endtask
  task automatic tBus;
    apply(9'h000);
    axiWrite(PRC_OFF_CAPCNT, 32'h0, r);
    @(posedge clk);
    cmd <= 9'h011;
    repeat (3) @(posedge clk);
    cmd <= 9'h000;
    axiRead(PRC_OFF_CAPCNT, d, r);
    check("capcnt", d, 32'h3);
    axiRead(4'hC, d, r);
    check("rdResp", 32'(r), 32'(PRC_RESP_SLVERR));
    check("rdData", d, 32'h0);
    axiWrite(PRC_OFF_STATUS, 32'h3F, r);
    check("roResp", 32'(r), 32'(PRC_RESP_OKAY));
    axiWrite(4'hC, 32'h1, r);
    check("wrResp", 32'(r), 32'(PRC_RESP_SLVERR));
    // Control bits only move when their byte lane is strobed
    s_axi_wstrb <= 4'hE;
    axiWrite(PRC_OFF_CTRL, 32'h1, r);
    s_axi_wstrb <= 4'hF;
    axiRead(PRC_OFF_CTRL, d, r);
    check("ctrlMasked", d, 32'h0);
    apply(9'h1D0);
    axiRead(PRC_OFF_STATUS, d, r);
    check("statusCtl", d, (32'h1 << PRC_ST_ACLR_BIT) |
      (32'h1 << PRC_ST_PRE_BIT) | (32'h1 << PRC_ST_ALOAD_BIT) |
      (32'h1 << PRC_ST_ENA_BIT));
    apply(9'h000);
    $display("test bus done");
  endtask
  task automatic conclude;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    tPowerUp;
    tPriority;
    tAsync;
    tInvert;
    tConst;
    tBus;
    conclude;
  end
  // About 1660 cycles are expected; 4000, well over twice that, means a hang
  initial begin
    repeat (4000) @(posedge clk);
    fails++;
    conclude;
  end
endmodule

// File: verilog/prc_cell_top.sv
// Prioritized register cell with its AXI4-Lite control and status slave
`timescale 1ns/100ps
// Behaviour
// - The raw storage bit is zero after power-up or reset.
// - Priority: aclr, preset, aload, enable, sync clear, sync load, data.
// - With enable low, sync clear and data are both ignored.
// - Sync clear acts only at a clock edge.
// - While aload alone is active, output follows load data continuously.
// - Inverted mode inverts input and output, showing one at zero.
// - Reset to a constant is an async load of it, without inversion.
// - Preset without native support is clear plus input/output inversion.
module prc_cell_top
  import prc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [PRC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [PRC_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [PRC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [PRC_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic aclr,
  input wire logic pre,
  input wire logic aload,
  input wire logic aData,
  input wire logic ena,
  input wire logic sclr,
  input wire logic sload,
  input wire logic sData,
  input wire logic data,
  output logic q,
  output logic rawBit
);
  typedef enum {PRC_WR_IDLE, PRC_WR_RESP} prc_wr_state_t;
  typedef enum {PRC_RD_IDLE, PRC_RD_DATA} prc_rd_state_t;

  function automatic logic prc_mapped(input logic [PRC_ADDR_W-1:0] addr);
    prc_mapped = (addr == PRC_OFF_CTRL) || (addr == PRC_OFF_STATUS) ||
                 (addr == PRC_OFF_CAPCNT);
  endfunction

  prc_wr_state_t wrState;
  prc_wr_state_t next_wrState;
  prc_rd_state_t rdState;
  prc_rd_state_t next_rdState;
  logic awHave;
  logic next_awHave;
  logic [PRC_ADDR_W-1:0] awAddr;
  logic [PRC_ADDR_W-1:0] next_awAddr;
  logic wHave;
  logic next_wHave;
  logic [PRC_DATA_W-1:0] wData;
  logic [PRC_DATA_W-1:0] next_wData;
  logic [3:0] wStrb;
  logic [3:0] next_wStrb;
  logic [1:0] bResp;
  logic [1:0] next_bResp;
  logic [PRC_DATA_W-1:0] rData;
  logic [PRC_DATA_W-1:0] next_rData;
  logic [1:0] rResp;
  logic [1:0] next_rResp;
  logic [PRC_CTRL_W-1:0] ctrl;
  logic [PRC_CTRL_W-1:0] next_ctrl;
  logic [PRC_DATA_W-1:0] capCount;
  logic [PRC_DATA_W-1:0] next_capCount;

  logic awFire;
  logic wFire;
  logic arFire;
  logic doWrite;
  logic [PRC_ADDR_W-1:0] curAddr;
  logic [PRC_DATA_W-1:0] curData;
  logic [3:0] curStrb;
  logic [PRC_DATA_W-1:0] statusWord;
  logic invertMode;
  logic loadConstEn;
  logic loadConst;
  logic cellAData;
  logic captured;

  assign invertMode = ctrl[PRC_CTRL_INV_BIT];
  assign loadConstEn = ctrl[PRC_CTRL_CONST_EN_BIT];
  assign loadConst = ctrl[PRC_CTRL_CONST_VAL_BIT];

  // A constant reset value goes in through the load path, not inversion
  assign cellAData = loadConstEn ? loadConst : aData;

  // Controls come from synchronous logic on clk; the driver keeps the
  // asynchronous group glitch free, so no synchroniser is placed here
  prc_storage_bit u_bit (
    .clk(clk),
    .rst(rst),
    .invertMode(invertMode),
    .aclr(aclr),
    .pre(pre),
    .aload(aload),
    .aData(cellAData),
    .ena(ena),
    .sclr(sclr),
    .sload(sload),
    .sData(sData),
    .data(data),
    .q(q),
    .rawBit(rawBit),
    .captured(captured)
  );

  always_comb begin
    statusWord = '0;
    statusWord[PRC_ST_Q_BIT] = q;
    statusWord[PRC_ST_RAW_BIT] = rawBit;
    statusWord[PRC_ST_ACLR_BIT] = aclr;
    statusWord[PRC_ST_PRE_BIT] = pre;
    statusWord[PRC_ST_ALOAD_BIT] = aload;
    statusWord[PRC_ST_ENA_BIT] = ena;
  end

  assign s_axi_awready = (wrState == PRC_WR_IDLE) && !awHave;
  assign s_axi_wready = (wrState == PRC_WR_IDLE) && !wHave;
  assign s_axi_arready = (rdState == PRC_RD_IDLE);
  assign s_axi_bvalid = (wrState == PRC_WR_RESP);
  assign s_axi_rvalid = (rdState == PRC_RD_DATA);
  assign s_axi_bresp = bResp;
  assign s_axi_rdata = rData;
  assign s_axi_rresp = rResp;

  assign awFire = s_axi_awvalid && s_axi_awready;
  assign wFire = s_axi_wvalid && s_axi_wready;
  assign arFire = s_axi_arvalid && s_axi_arready;
  assign curAddr = awHave ? awAddr : s_axi_awaddr;
  assign curData = wHave ? wData : s_axi_wdata;
  assign curStrb = wHave ? wStrb : s_axi_wstrb;
  assign doWrite = (wrState == PRC_WR_IDLE) && (awHave || awFire) &&
                   (wHave || wFire);

  // Write channel: address and data taken in either order
  always_comb begin
    next_wrState = wrState;
    next_awHave = awHave;
    next_awAddr = awAddr;
    next_wHave = wHave;
    next_wData = wData;
    next_wStrb = wStrb;
    next_bResp = bResp;
    case (wrState)
      PRC_WR_IDLE: begin
        if (awFire) begin
          next_awHave = 1'b1;
          next_awAddr = s_axi_awaddr;
        end
        if (wFire) begin
          next_wHave = 1'b1;
          next_wData = s_axi_wdata;
          next_wStrb = s_axi_wstrb;
        end
        if (doWrite) begin
          next_awHave = 1'b0;
          next_wHave = 1'b0;
          next_bResp = prc_mapped(curAddr) ? PRC_RESP_OKAY : PRC_RESP_SLVERR;
          next_wrState = PRC_WR_RESP;
        end
      end
      PRC_WR_RESP: begin
        if (s_axi_bready) begin
          next_wrState = PRC_WR_IDLE;
        end
      end
      default: begin
        next_wrState = PRC_WR_IDLE;
      end
    endcase
  end

  // Register effects: control word, and capture counter cleared on write
  always_comb begin
    next_ctrl = ctrl;
    next_capCount = capCount;
    if (doWrite && (curAddr == PRC_OFF_CTRL) && curStrb[0]) begin
      next_ctrl = curData[PRC_CTRL_W-1:0];
    end
    if (doWrite && (curAddr == PRC_OFF_CAPCNT)) begin
      next_capCount = PRC_CAPCNT_RESET;
    end
    // A capture in the clearing cycle still counts
    if (captured) begin
      next_capCount = next_capCount + 32'h0000_0001;
    end
  end

  // Read channel: one read under way, data registered
  always_comb begin
    next_rdState = rdState;
    next_rData = rData;
    next_rResp = rResp;
    case (rdState)
      PRC_RD_IDLE: begin
        if (arFire) begin
          next_rdState = PRC_RD_DATA;
          next_rResp = prc_mapped(s_axi_araddr) ? PRC_RESP_OKAY :
                       PRC_RESP_SLVERR;
          next_rData = '0;
          if (s_axi_araddr == PRC_OFF_CTRL) begin
            next_rData[PRC_CTRL_W-1:0] = ctrl;
          end else if (s_axi_araddr == PRC_OFF_STATUS) begin
            next_rData = statusWord;
          end else if (s_axi_araddr == PRC_OFF_CAPCNT) begin
            next_rData = capCount;
          end
        end
      end
      PRC_RD_DATA: begin
        if (s_axi_rready) begin
          next_rdState = PRC_RD_IDLE;
        end
      end
      default: begin
        next_rdState = PRC_RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrState <= PRC_WR_IDLE;
      awHave <= 1'b0;
      awAddr <= '0;
      wHave <= 1'b0;
      wData <= '0;
      wStrb <= 4'h0;
      bResp <= PRC_RESP_OKAY;
    end else begin
      wrState <= next_wrState;
      awHave <= next_awHave;
      awAddr <= next_awAddr;
      wHave <= next_wHave;
      wData <= next_wData;
      wStrb <= next_wStrb;
      bResp <= next_bResp;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= PRC_CTRL_RESET;
      capCount <= PRC_CAPCNT_RESET;
    end else begin
      ctrl <= next_ctrl;
      capCount <= next_capCount;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdState <= PRC_RD_IDLE;
      rData <= '0;
      rResp <= PRC_RESP_OKAY;
    end else begin
      rdState <= next_rdState;
      rData <= next_rData;
      rResp <= next_rResp;
    end
  end
endmodule

// File: verilog/prc_storage_bit.sv
// Single storage bit with the fixed-priority control ladder
`timescale 1ns/100ps
module prc_storage_bit
  import prc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic invertMode,
  input wire logic aclr,
  input wire logic pre,
  input wire logic aload,
  input wire logic aData,
  input wire logic ena,
  input wire logic sclr,
  input wire logic sload,
  input wire logic sData,
  input wire logic data,
  output logic q,
  output logic rawBit,
  output logic captured
);
  logic raw;
  logic next_raw;
  logic asyncActive;
  logic asyncValue;
  logic syncValue;

  // Observed-domain value demanded by the asynchronous group
  always_comb begin
    asyncActive = aclr | pre | aload;
    if (aclr) begin
      asyncValue = 1'b0;
    end else if (pre) begin
      asyncValue = 1'b1;
    end else begin
      asyncValue = aData;
    end
  end

  // Enable gates both synchronous clear and data
  always_comb begin
    if (sclr) begin
      syncValue = 1'b0;
    end else if (sload) begin
      syncValue = sData;
    end else begin
      syncValue = data;
    end
  end

  // Raw bit holds the observed value xor the inversion, so a preset in
  // inverted mode lands as a raw clear and a clear as a raw set
  always_comb begin
    next_raw = raw;
    if (asyncActive) begin
      next_raw = asyncValue ^ invertMode;
    end else if (ena) begin
      next_raw = syncValue ^ invertMode;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      raw <= PRC_RAW_POWERUP;
    end else begin
      raw <= next_raw;
    end
  end

  // Asynchronous group overrides the output without waiting for clk; the stored bit takes its value at the next clk edge
  assign q = asyncActive ? asyncValue : (raw ^ invertMode);
  assign rawBit = raw;
  assign captured = ~asyncActive & ena & ~sclr & ~sload;
endmodule
